/* File: hpoc_consts.vh */
`ifndef HPOC_CONSTS_VH
`define HPOC_CONSTS_VH
// register offsets within a page
`define HPOC_OFF_PAGE_SEL    7'h00
`define HPOC_OFF_OC_CFG      7'h0B
`define HPOC_OFF_ROUTE       7'h0C
`define HPOC_OFF_RSVD_FIRST  7'h0D
`define HPOC_OFF_RSVD_LAST   7'h0F
// page that holds this bank
`define HPOC_PAGE_THIS       8'h01
// over-current config fields
`define HPOC_OC_ACTION_BIT   0
`define HPOC_OC_DEB_LSB      1
`define HPOC_OC_DEB_MSB      3
`define HPOC_OC_FIXED_BIT    4
`define HPOC_OC_RESET        8'h10
`define HPOC_OC_WMASK        8'h1F
// routing fields
`define HPOC_RT_RIGHT_ATT    0
`define HPOC_RT_LEFT_ATT     1
`define HPOC_RT_MIX_ATT      2
`define HPOC_RT_DAC_DIRECT   3
`define HPOC_RT_AN_LSB       4
`define HPOC_RT_AN_MSB       7
`define HPOC_RT_RESET        8'h00
// analog routing codes
`define HPOC_AN_NONE         4'h0
`define HPOC_AN_RIGHT_MIXP   4'h4
`define HPOC_AN_DIFF_A       4'h6
`define HPOC_AN_LEFT_MIXA    4'h8
`define HPOC_AN_DIFF_B       4'h9
`define HPOC_AN_BOTH_HP      4'hC
// debounce timing, base interval for code 001
`define HPOC_DEB_BASE_MS     8
`define HPOC_CLK_HZ          100000000
`endif

/* File: hpoc_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "hpoc_consts.vh"
// What this block does
// - debounce codes 001..111 give 8ms doubling to 512ms
// - code 000 acts at once, reset value
// - action bit 0 limits current, driver stays on
// - action bit 1 powers headphone driver down
// - over-current top three bits read zero
// - routing field resets 0000, nothing routed
// - code 0100 routes right input to mixer P
// - code 1000 routes left input to mixer A
// - codes 0110, 1001 give differential speaker path
// - code 1100 routes both inputs to headphone
// - DAC direct bit connects DAC to headphone
// - mixer bit connects mixer P to attenuator
// - left attenuator bit routes to headphone
// - right attenuator bit routes to headphone
// - offsets 0D..0F read zero, writes ignored
// - offset zero holds the page selector
module hpoc_regs #(
  parameter BASE_CYCLES = `HPOC_DEB_BASE_MS * (`HPOC_CLK_HZ / 1000)
) (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire [6:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata,
  input  wire       ocDetectRaw,
  output reg        ocLimitCurrent,
  output reg        ocPowerDown,
  output reg        ocTripped,
  output reg        rightToMixP,
  output reg        leftToMixA,
  output reg        diffToSpeaker,
  output reg        bothToHeadphone,
  output reg        dacToHeadphone,
  output reg        mixPToAtten,
  output reg        leftAttToHeadphone,
  output reg        rightAttToHeadphone,
  output reg  [7:0] pageSel
);

  reg  [7:0]  ocCfg_q;
  reg  [7:0]  route_q;
  reg         ocSync1_q;
  reg         ocSync2_q;
  reg  [35:0] debCnt_q;
  reg  [35:0] debCnt_d;
  reg         trip_q;
  reg         trip_d;
  reg  [35:0] debLimit;
  reg  [7:0]  rdNext;
  // widened by four bits here so the shifts below keep the top bits while the base stays under 2^30
  localparam [35:0] BASE_WIDE = {4'h0, BASE_CYCLES[31:0]};
  wire [2:0]  debSel  = ocCfg_q[`HPOC_OC_DEB_MSB:`HPOC_OC_DEB_LSB];
  wire [3:0]  anRoute = route_q[`HPOC_RT_AN_MSB:`HPOC_RT_AN_LSB];
  wire        onPage  = (pageSel == `HPOC_PAGE_THIS);
  wire        codeRightMixP = (anRoute == `HPOC_AN_RIGHT_MIXP);
  wire        codeLeftMixA  = (anRoute == `HPOC_AN_LEFT_MIXA);
  wire        codeDiffSpk   = (anRoute == `HPOC_AN_DIFF_A) | (anRoute == `HPOC_AN_DIFF_B);
  wire        codeBothHp    = (anRoute == `HPOC_AN_BOTH_HP);
  wire        actPowerDown  = ocCfg_q[`HPOC_OC_ACTION_BIT];

  // page selector answers at offset zero whatever page is selected
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pageSel <= 8'h00;
    end
    else if (regWrite && regAddr == `HPOC_OFF_PAGE_SEL)
    begin
      pageSel <= regWdata;
    end
  end

  // top bits forced zero, fixed bit forced one, whatever software sends
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ocCfg_q <= `HPOC_OC_RESET;
    end
    else if (regWrite && onPage && regAddr == `HPOC_OFF_OC_CFG)
    begin
      ocCfg_q <= (regWdata & `HPOC_OC_WMASK) | `HPOC_OC_RESET;
    end
  end

  // any code is stored; unusable codes decode to nothing below
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      route_q <= `HPOC_RT_RESET;
    end
    else if (regWrite && onPage && regAddr == `HPOC_OFF_ROUTE)
    begin
      route_q <= regWdata;
    end
  end

  // read mux; reserved and unmapped offsets give zero
  always @*
  begin
    rdNext = 8'h00;
    if (regAddr == `HPOC_OFF_PAGE_SEL)
      rdNext = pageSel;
    else if (onPage && regAddr == `HPOC_OFF_OC_CFG)
      rdNext = ocCfg_q;
    else if (onPage && regAddr == `HPOC_OFF_ROUTE)
      rdNext = route_q;
    else if (regAddr >= `HPOC_OFF_RSVD_FIRST && regAddr <= `HPOC_OFF_RSVD_LAST)
      rdNext = 8'h00;
  end

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (regRead)
      regRdata <= rdNext;
    else
      regRdata <= 8'h00;
  end

  // detector is analog, so synchronise it first
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      ocSync1_q <= 1'b0;
    else
      ocSync1_q <= ocDetectRaw;
  end

  // only this second stage is read by the logic
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      ocSync2_q <= 1'b0;
    else
      ocSync2_q <= ocSync1_q;
  end

  // interval doubles per code step; code 000 leaves the limit at zero
  always @*
  begin
    debLimit = 36'h0;
    case (debSel)
      3'h1: debLimit = BASE_WIDE;
      3'h2: debLimit = BASE_WIDE << 1;
      3'h3: debLimit = BASE_WIDE << 2;
      3'h4: debLimit = BASE_WIDE << 3;
      3'h5: debLimit = BASE_WIDE << 4;
      3'h6: debLimit = BASE_WIDE << 5;
      3'h7: debLimit = BASE_WIDE << 6;
      default: debLimit = 36'h0;
    endcase
  end

  // trip holds while the indication stays up; a setting change applies live
  always @*
  begin
    debCnt_d = debCnt_q;
    trip_d   = trip_q;
    if (!ocSync2_q)
    begin
      debCnt_d = 36'h0;
      trip_d   = 1'b0;
    end
    else if (debSel == 3'h0)
      trip_d = 1'b1;
    else if (debCnt_q + 36'h1 >= debLimit)
      trip_d = 1'b1;
    else
      debCnt_d = debCnt_q + 36'h1;
  end

  // debounce count; cleared at once when the indication drops
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      debCnt_q <= 36'h0;
    end
    else
    begin
      debCnt_q <= debCnt_d;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      trip_q <= 1'b0;
    end
    else
    begin
      trip_q <= trip_d;
    end
  end

  // outputs registered; they follow the stored fields one cycle late
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ocTripped <= 1'b0;
    end
    else
    begin
      ocTripped <= trip_q;
    end
  end

  // limiting keeps the driver powered
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ocLimitCurrent <= 1'b0;
    end
    else
    begin
      ocLimitCurrent <= trip_q & ~actPowerDown;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ocPowerDown <= 1'b0;
    end
    else
    begin
      ocPowerDown <= trip_q & actPowerDown;
    end
  end

  // unusable codes route nothing, same as 0000
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rightToMixP <= 1'b0;
    end
    else
    begin
      rightToMixP <= codeRightMixP;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      leftToMixA <= 1'b0;
    end
    else
    begin
      leftToMixA <= codeLeftMixA;
    end
  end

  // the ambiguous 1010 entry is treated as unusable
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      diffToSpeaker <= 1'b0;
    end
    else
    begin
      diffToSpeaker <= codeDiffSpk;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      bothToHeadphone <= 1'b0;
    end
    else
    begin
      bothToHeadphone <= codeBothHp;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dacToHeadphone <= 1'b0;
    end
    else
    begin
      dacToHeadphone <= route_q[`HPOC_RT_DAC_DIRECT];
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mixPToAtten <= 1'b0;
    end
    else
    begin
      mixPToAtten <= route_q[`HPOC_RT_MIX_ATT];
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      leftAttToHeadphone <= 1'b0;
    end
    else
    begin
      leftAttToHeadphone <= route_q[`HPOC_RT_LEFT_ATT];
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rightAttToHeadphone <= 1'b0;
    end
    else
    begin
      rightAttToHeadphone <= route_q[`HPOC_RT_RIGHT_ATT];
    end
  end

endmodule // hpoc_regs
`default_nettype wire

/* File: hpoc_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module hpoc_regs_chk (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       ocDetectRaw,
  input wire logic       ocTripped,
  input wire logic       ocLimitCurrent,
  input wire logic       ocPowerDown,
  input wire logic       dacToHeadphone,
  input wire logic [7:0] pageSel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence rtWr;
    regWrite && regAddr == 7'h0C && pageSel == 8'h01;
  endsequence
  page_write_a: assert property (regWrite && regAddr == 7'h00 |=> pageSel == $past(regWdata))
    else $error("page selector not taken");
  limit_only_a: assert property (ocLimitCurrent |-> ocTripped && !ocPowerDown)
    else $error("limit without trip or with power down");
  power_down_a: assert property (ocPowerDown |-> ocTripped && !ocLimitCurrent)
    else $error("power down without trip or with limit");
  trip_drop_a: assert property (!ocDetectRaw [*6] |-> !ocTripped)
    else $error("trip held after indication dropped");
  trip_cause_a: assert property ($rose(ocTripped) |-> $past(ocDetectRaw, 4))
    else $error("trip without indication");
  cfg_fixed_a: assert property (regRead && regAddr == 7'h0B && pageSel == 8'h01
    |=> regRdata[7:4] == 4'h1)
    else $error("fixed config bits wrong");
  rsvd_zero_a: assert property (regRead && regAddr >= 7'h0D && regAddr <= 7'h0F
    |=> regRdata == 8'h00)
    else $error("reserved read not zero");
  dac_apply_a: assert property (rtWr |=> ##1 dacToHeadphone == $past(regWdata[3], 2))
    else $error("direct path not applied");
endmodule // hpoc_regs_chk
`default_nettype wire

/* File: hpoc_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module hpoc_regs_bench;
  logic       sys_clk = 0;
  logic       rst_n = 0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 0;
  logic       regRead = 0;
  logic       ocDetectRaw = 0;
  wire  [7:0] regRdata, pageSel;
  wire        lim, pdn, trip, r2p, l2a, dif, both, dac, mix, la, ra;
  int         failures = 0, compares = 0, cyc = 0;
  // write value beside the routing outputs it gives; unusable codes route nothing
  logic [15:0] rows [8] = '{16'h0000, 16'h4888, 16'h8444, 16'h6222,
                            16'h9121, 16'hC010, 16'hA000, 16'h3F0F};
  hpoc_regs #(.BASE_CYCLES(10)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .ocDetectRaw(ocDetectRaw), .ocLimitCurrent(lim), .ocPowerDown(pdn), .ocTripped(trip),
    .rightToMixP(r2p), .leftToMixA(l2a), .diffToSpeaker(dif), .bothToHeadphone(both),
    .dacToHeadphone(dac), .mixPToAtten(mix), .leftAttToHeadphone(la),
    .rightAttToHeadphone(ra), .pageSel(pageSel));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (++cyc == 3000)
    begin
      failures++;
      wrap_up();
    end
  task chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1;
    @(posedge sys_clk);
    regWrite <= 0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1;
    @(posedge sys_clk);
    regRead <= 0;
    @(negedge sys_clk);
    chk(regRdata, e);
  endtask
  // settle n edges, then look mid-cycle away from any edge
  task hold(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task raw(input logic v);
    @(posedge sys_clk);
    ocDetectRaw <= v;
  endtask
  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    rd(7'h0B, 8'h00);
    wr(7'h00, 8'h01);
    rd(7'h0B, 8'h10);
    rd(7'h0C, 8'h00);
    foreach (rows[i])
    begin
      wr(7'h0C, rows[i][15:8]);
      hold(2);
      chk({r2p, l2a, dif, both, dac, mix, la, ra}, rows[i][7:0]);
    end
    wr(7'h0B, 8'h11);
    raw(1);
    hold(6);
    chk({trip, lim, pdn}, 8'h05);
    raw(0);
    hold(6);
    chk({trip, lim, pdn}, 8'h00);
    wr(7'h0B, 8'h12);
    raw(1);
    hold(8);
    raw(0);
    raw(1);
    hold(8);
    chk({trip, lim, pdn}, 8'h00);
    hold(10);
    chk({trip, lim, pdn}, 8'h06);
    raw(0);
    wr(7'h0B, 8'hEE);
    rd(7'h0B, 8'h1E);
    wr(7'h0E, 8'hFF);
    rd(7'h0E, 8'h00);
    wr(7'h00, 8'h02);
    hold(0);
    chk(pageSel, 8'h02);
    rd(7'h0C, 8'h00);
    @(posedge sys_clk) rst_n <= 0;
    @(posedge sys_clk) rst_n <= 1;
    rd(7'h00, 8'h00);
    wrap_up();
  end
endmodule // hpoc_regs_bench
bind hpoc_regs hpoc_regs_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .ocDetectRaw(ocDetectRaw), .ocTripped(ocTripped), .ocLimitCurrent(ocLimitCurrent),
  .ocPowerDown(ocPowerDown), .dacToHeadphone(dacToHeadphone), .pageSel(pageSel));
`default_nettype wire
